// *** hdl/gcc_regs.svh ***
// named constants of the controller command core: codes, bit positions, timing
// assumes a 25 MHz core clock; included by bare name from the timer and core modules
`ifndef GCC_REGS_SVH
`define GCC_REGS_SVH

// core clock rate
`define GCC_CLK_MHZ 25

// command byte layout
`define GCC_CMD_TOP_HI 7
`define GCC_CMD_TOP_LO 5
`define GCC_CMD_TOP_ONES 3'h7
`define GCC_CMD_OP_BIT 4
`define GCC_IRQ_ACKNOWLEDGE_CMD_BIT3 3
`define GCC_IRQ_ACKNOWLEDGE_CMD_BIT1 1
`define GCC_IRQ_ACKNOWLEDGE_CMD_BIT0 0

// operation commands
`define GCC_CMD_CNT_IRQ_OFF 8'hf0
`define GCC_CMD_GO_IDLE 8'hf1
`define GCC_CMD_SOFT_RESET 8'hf2
`define GCC_CMD_CLEAR_IRQS 8'hf3
`define GCC_CMD_STANDBY_COUNT 8'hf4
`define GCC_CMD_PAR_POLL 8'hf5
`define GCC_CMD_GO_STANDBY 8'hf6
`define GCC_CMD_LOCAL_MODE 8'hf7
`define GCC_CMD_REMOTE_MODE 8'hf8
`define GCC_CMD_ABORT 8'hf9
`define GCC_CMD_TAKE_CTRL 8'hfa
`define GCC_CMD_TAKE_SYNC 8'hfd
`define GCC_CMD_CNT_IRQ_ON 8'hfe

// utility commands
`define GCC_CMD_WR_TIMEOUT 8'he1
`define GCC_CMD_WR_COUNT 8'he2
`define GCC_CMD_RD_COUNT 8'he3
`define GCC_CMD_RD_FAULTS 8'he4
`define GCC_CMD_RD_CTRL 8'he6
`define GCC_CMD_RD_BUS 8'he7
`define GCC_CMD_RD_TIMEOUT 8'he9
`define GCC_CMD_RD_FAULT_EN 8'hea

// interrupt status bit positions
`define GCC_ISR_SYC 7
`define GCC_ISR_ERR 6
`define GCC_ISR_SRQ 5
`define GCC_ISR_EV 4
`define GCC_ISR_IFCR 2
`define GCC_ISR_OBF 0

// fault flag and fault enable bit positions, writable mask
`define GCC_ERR_USER 5
`define GCC_ERR_SYNC_TAKE 2
`define GCC_ERR_XFER_START 1
`define GCC_ERR_HANDOVER 0
`define GCC_ERR_MASK 8'h27

// controller state status bit positions
`define GCC_CSR_STANDBY 7
`define GCC_CSR_ACTIVE 6
`define GCC_CSR_SYSCON 3
`define GCC_CSR_IFC 2
`define GCC_CSR_REN 1
`define GCC_CSR_SRQ 0

// timeout prescaler periods in core cycles per count
`define GCC_TO_SLOW_CYC 11'd1800
`define GCC_TO_FAST_CYC 11'd45

// bus timing: times as printed, cycle counts derived
`define GCC_IFC_US 100
`define GCC_IFC_CYC (`GCC_IFC_US * `GCC_CLK_MHZ)
`define GCC_T10_NS 1500
`define GCC_T10_CYC ((`GCC_T10_NS * `GCC_CLK_MHZ + 999) / 1000)
`define GCC_POLL_NS 2000
`define GCC_POLL_CYC ((`GCC_POLL_NS * `GCC_CLK_MHZ + 999) / 1000)

`endif

// *** hdl/gcc_pkg.sv ***
// types of the controller command core: pin carrier, states, register state
// assumes gcc_regs.svh holds every numeric constant
package gcc_pkg;

    // bus pin levels, high means asserted on the bus
    typedef struct packed {
        logic ren;
        logic dav;
        logic eoi;
        logic syscon_switch;
        logic ifc;
        logic attention_in;
        logic srq;
        logic count;
        logic ifcl;
    } gcc_bus_s;

    // controller function states, one-hot
    typedef enum logic [5:0] {
        GCC_IDLE      = 6'h01,
        GCC_ACTIVE    = 6'h02,
        GCC_ACT_WAIT  = 6'h04,
        GCC_STANDBY   = 6'h08,
        GCC_SYNC_WAIT = 6'h10,
        GCC_HANDOVER  = 6'h20
    } gcc_ctl_e;

    // what a data byte written with the select line low goes to
    typedef enum logic [1:0] {
        GCC_TO_MASK    = 2'h0,
        GCC_TO_TIMEOUT = 2'h1,
        GCC_TO_COUNT   = 2'h2
    } gcc_dest_e;

    // timeout counter state
    typedef struct packed {
        logic [10:0] pre;
        logic [7:0] value;
        logic expire;
    } gcc_tmr_s;

endpackage

// *** hdl/gcc_tmr.sv ***
// timeout down counter with a prescaler that sets the cycles per count
// assumes load, run and slow come from logic on the same clock
`timescale 1ns/1ns
`include "gcc_regs.svh"

module gcc_tmr (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic load_i,
    input wire logic run_i,
    input wire logic slow_i,
    input wire logic [7:0] reload_i,
    output logic [7:0] value_o,
    output logic expire_o
);
    gcc_pkg::gcc_tmr_s s_q;
    gcc_pkg::gcc_tmr_s s_d;
    logic [10:0] period;

    // next state: load, count down, one-cycle expiry pulse
    always_comb begin
        s_d = s_q;
        s_d.expire = 1'b0;
        period = slow_i ? `GCC_TO_SLOW_CYC : `GCC_TO_FAST_CYC;
        if (!resetn_i) begin
            s_d = '0;
        end else if (load_i) begin
            s_d.value = reload_i;
            s_d.pre = '0;
        end else if (run_i && s_q.value != 8'h00) begin
            if (s_q.pre == period - 11'd1) begin
                s_d.pre = '0;
                s_d.value = s_q.value - 8'h01;
                s_d.expire = (s_q.value == 8'h01);
            end else begin
                s_d.pre = s_q.pre + 11'd1;
            end
        end
    end

    // value holds when not running, so the last figure stays readable
    always_ff @(posedge clock_i) begin
        s_q <= s_d;
    end

    assign value_o = s_q.value;
    assign expire_o = s_q.expire;
endmodule

// *** hdl/gcc_core.sv ***
// controller command core: host command port, status registers, bus control
// assumes host strobes on clock_i, bus pins asynchronous and synchronised here
`timescale 1ns/1ns
`include "gcc_regs.svh"

module gcc_core (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic port_select_line_i,
    input wire logic [7:0] host_data_i,
    input wire gcc_pkg::gcc_bus_s bus_i,
    output logic [7:0] host_data_o,
    output logic [7:0] irq_status_o,
    output logic out_full_o,
    output logic task_complete_irq_o,
    output logic special_irq_o,
    output logic attention_out_n_o,
    output logic in_charge_out_n_o,
    output logic ren_out_o,
    output logic ifc_out_o,
    output logic eoi_out_o
);
    // whole register state of the core
    typedef struct packed {
        gcc_pkg::gcc_bus_s sync1;
        gcc_pkg::gcc_bus_s sync2;
        gcc_pkg::gcc_bus_s sync3;
        gcc_pkg::gcc_ctl_e ctl;
        gcc_pkg::gcc_dest_e dest;
        logic attn_n;
        logic cic_n;
        logic ren_out;
        logic ifc_out;
        logic eoi_out;
        logic [7:0] isr;
        logic spi;
        logic task_complete_irq;
        logic [7:0] obuf;
        logic obf;
        logic [7:0] err;
        logic [7:0] emask;
        logic [7:0] evc_init;
        logic [7:0] evc;
        logic cnt_en;
        logic ev_irq_en;
        logic [7:0] to_reload;
        logic armed;
        logic [11:0] hold;
        logic [11:0] ifc_cnt;
    } gcc_core_s;

    gcc_core_s s_q;
    gcc_core_s s_d;
    logic [7:0] new_err;
    logic [7:0] csr;
    logic [7:0] bsr;
    logic is_cmd;
    logic soft_rst;
    logic tmr_load;
    logic tmr_run;
    logic tmr_slow;
    logic tmr_exp;
    logic [7:0] tmr_value;
    logic cnt_edge;
    logic syscon;

    // timeout runs in the two take-control loops and while a transfer is awaited
    assign tmr_run = (s_q.ctl == gcc_pkg::GCC_HANDOVER) ||
                     (s_q.ctl == gcc_pkg::GCC_SYNC_WAIT) ||
                     (s_q.ctl == gcc_pkg::GCC_STANDBY && s_q.armed);
    assign tmr_slow = (s_q.ctl != gcc_pkg::GCC_STANDBY);

    // soft reset clears the timeout counter exactly like the external reset
    gcc_tmr i_gcc_tmr (
        .clock_i(clock_i),
        .resetn_i(resetn_i & ~soft_rst),
        .load_i(tmr_load),
        .run_i(tmr_run),
        .slow_i(tmr_slow),
        .reload_i(s_q.to_reload),
        .value_o(tmr_value),
        .expire_o(tmr_exp)
    );

    // status words assembled from state and synchronised pins
    always_comb begin
        syscon = s_q.sync2.syscon_switch;
        cnt_edge = s_q.sync2.count & ~s_q.sync3.count;
        csr = 8'h00;
        csr[`GCC_CSR_STANDBY] = (s_q.ctl == gcc_pkg::GCC_STANDBY);
        csr[`GCC_CSR_ACTIVE] = (s_q.ctl == gcc_pkg::GCC_ACTIVE) ||
                               (s_q.ctl == gcc_pkg::GCC_ACT_WAIT) ||
                               (s_q.ctl == gcc_pkg::GCC_SYNC_WAIT);
        csr[`GCC_CSR_SYSCON] = syscon;
        csr[`GCC_CSR_IFC] = s_q.ifc_out | s_q.sync2.ifc;
        csr[`GCC_CSR_REN] = s_q.ren_out;
        csr[`GCC_CSR_SRQ] = s_q.sync2.srq;
        bsr = {s_q.sync2.ren, s_q.sync2.dav, s_q.sync2.eoi, 1'b0,
               s_q.sync2.syscon_switch, s_q.sync2.ifc, s_q.sync2.attention_in, s_q.sync2.srq};
    end

    // next-state logic of the whole core
    always_comb begin
        s_d = s_q;
        new_err = 8'h00;
        tmr_load = 1'b0;
        is_cmd = host_wr_i && port_select_line_i;
        soft_rst = is_cmd && host_data_i == `GCC_CMD_SOFT_RESET;
        // two-stage pin synchroniser plus an edge stage
        s_d.sync1 = bus_i;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        // host read of the output byte empties it
        if (host_rd_i && !port_select_line_i) begin
            s_d.obf = 1'b0;
        end
        // service request and switch change events
        if (s_q.sync2.srq && !s_q.sync3.srq) begin
            s_d.isr[`GCC_ISR_SRQ] = 1'b1;
        end
        if (s_q.sync2.syscon_switch != s_q.sync3.syscon_switch) begin
            s_d.isr[`GCC_ISR_SYC] = 1'b1;
        end
        // event counter, wraps so underflow repeats every 256 pulses
        if (s_q.cnt_en && cnt_edge) begin
            s_d.evc = s_q.evc - 8'h01;
            if (s_q.evc == 8'h01 && s_q.ev_irq_en) begin
                s_d.isr[`GCC_ISR_EV] = 1'b1;
            end
        end
        // interface clear pulse length
        if (s_q.ifc_out) begin
            if (s_q.ifc_cnt == 12'(`GCC_IFC_CYC) - 12'd1) begin
                s_d.ifc_out = 1'b0;
            end else begin
                s_d.ifc_cnt = s_q.ifc_cnt + 12'd1;
            end
        end
        // controller function sequencing
        unique case (s_q.ctl)
            gcc_pkg::GCC_HANDOVER: begin
                if (!s_q.sync2.attention_in) begin
                    s_d.ctl = gcc_pkg::GCC_ACTIVE;
                    s_d.attn_n = 1'b0;
                    s_d.cic_n = 1'b0;
                    s_d.task_complete_irq = 1'b1;
                end
            end
            gcc_pkg::GCC_SYNC_WAIT: begin
                if (s_q.sync2.dav) begin
                    s_d.hold = '0;
                end else if (s_q.hold == 12'(`GCC_T10_CYC) - 12'd1) begin
                    s_d.ctl = gcc_pkg::GCC_ACTIVE;
                    s_d.attn_n = 1'b0;
                    s_d.task_complete_irq = 1'b1;
                end else begin
                    s_d.hold = s_q.hold + 12'd1;
                end
            end
            gcc_pkg::GCC_ACT_WAIT: begin
                if (s_q.hold == 12'(`GCC_POLL_CYC) - 12'd1) begin
                    s_d.eoi_out = 1'b0;
                    s_d.ctl = gcc_pkg::GCC_ACTIVE;
                    s_d.task_complete_irq = 1'b1;
                end else begin
                    s_d.hold = s_q.hold + 12'd1;
                end
            end
            gcc_pkg::GCC_STANDBY: begin
                if (s_q.sync2.dav) begin
                    s_d.armed = 1'b0;
                end
            end
            gcc_pkg::GCC_IDLE, gcc_pkg::GCC_ACTIVE: begin
                s_d.hold = '0;
            end
        endcase
        // timeout expiry picks the fault of the running function
        if (tmr_exp) begin
            unique case (s_q.ctl)
                gcc_pkg::GCC_HANDOVER: new_err[`GCC_ERR_HANDOVER] = 1'b1;
                gcc_pkg::GCC_SYNC_WAIT: new_err[`GCC_ERR_SYNC_TAKE] = 1'b1;
                gcc_pkg::GCC_STANDBY: new_err[`GCC_ERR_XFER_START] = 1'b1;
                default: new_err = 8'h00;
            endcase
            s_d.armed = 1'b0;
        end
        // data byte with select low
        if (host_wr_i && !port_select_line_i) begin
            unique case (s_q.dest)
                gcc_pkg::GCC_TO_TIMEOUT: s_d.to_reload = host_data_i;
                gcc_pkg::GCC_TO_COUNT: begin
                    s_d.evc_init = host_data_i;
                    s_d.evc = host_data_i;
                end
                default: s_d.emask = host_data_i & `GCC_ERR_MASK;
            endcase
            s_d.dest = gcc_pkg::GCC_TO_MASK;
        end
        // command byte with select high
        if (is_cmd) begin
            s_d.task_complete_irq = 1'b0;
            s_d.dest = gcc_pkg::GCC_TO_MASK;
            if (host_data_i[`GCC_IRQ_ACKNOWLEDGE_CMD_BIT3] && host_data_i[`GCC_IRQ_ACKNOWLEDGE_CMD_BIT1] &&
                host_data_i[`GCC_IRQ_ACKNOWLEDGE_CMD_BIT0]) begin
                // acknowledge clears each named status flag
                // a flag raised in this same cycle survives the acknowledge
                s_d.isr = (s_q.isr & ~host_data_i) | (s_d.isr & ~s_q.isr);
                if (s_q.isr[`GCC_ISR_ERR] && !host_data_i[`GCC_ISR_ERR]) begin
                    s_d.obuf = s_q.err;
                    s_d.obf = 1'b1;
                    s_d.task_complete_irq = 1'b1;
                end
            end else if (host_data_i[`GCC_CMD_TOP_HI:`GCC_CMD_TOP_LO] == `GCC_CMD_TOP_ONES &&
                         !host_data_i[`GCC_CMD_OP_BIT]) begin
                // utility commands: register transfers
                s_d.task_complete_irq = 1'b1;
                unique case (host_data_i)
                    `GCC_CMD_WR_TIMEOUT: begin
                        s_d.dest = gcc_pkg::GCC_TO_TIMEOUT;
                        s_d.task_complete_irq = 1'b0;
                    end
                    `GCC_CMD_WR_COUNT: begin
                        s_d.dest = gcc_pkg::GCC_TO_COUNT;
                        s_d.task_complete_irq = 1'b0;
                    end
                    `GCC_CMD_RD_COUNT: s_d.obuf = s_q.evc;
                    `GCC_CMD_RD_FAULTS: s_d.obuf = s_q.err;
                    `GCC_CMD_RD_CTRL: s_d.obuf = csr;
                    `GCC_CMD_RD_BUS: s_d.obuf = bsr;
                    `GCC_CMD_RD_TIMEOUT: s_d.obuf = tmr_value;
                    `GCC_CMD_RD_FAULT_EN: s_d.obuf = s_q.emask;
                    default: s_d.task_complete_irq = 1'b0;
                endcase
                s_d.obf = s_d.task_complete_irq | s_q.obf;
            end else if (host_data_i[`GCC_CMD_TOP_HI:`GCC_CMD_TOP_LO] == `GCC_CMD_TOP_ONES) begin
                // operation commands: bus actions
                unique case (host_data_i)
                    `GCC_CMD_CNT_IRQ_OFF: s_d.ev_irq_en = 1'b0;
                    `GCC_CMD_CNT_IRQ_ON: s_d.ev_irq_en = 1'b1;
                    `GCC_CMD_GO_IDLE: begin
                        if (s_q.ctl == gcc_pkg::GCC_ACTIVE) begin
                            s_d.attn_n = 1'b1;
                            s_d.cic_n = 1'b1;
                            s_d.ctl = gcc_pkg::GCC_IDLE;
                            s_d.task_complete_irq = 1'b1;
                        end
                    end
                    `GCC_CMD_CLEAR_IRQS: begin
                        s_d.isr = s_d.isr & ~s_q.isr;
                        s_d.err = 8'h00;
                        s_d.armed = 1'b0;
                        if (s_q.ctl == gcc_pkg::GCC_HANDOVER) begin
                            s_d.ctl = gcc_pkg::GCC_IDLE;
                        end
                        if (s_q.ctl == gcc_pkg::GCC_SYNC_WAIT) begin
                            s_d.ctl = gcc_pkg::GCC_STANDBY;
                        end
                    end
                    `GCC_CMD_STANDBY_COUNT: begin
                        if (s_q.ctl == gcc_pkg::GCC_ACTIVE) begin
                            s_d.attn_n = 1'b1;
                            s_d.ctl = gcc_pkg::GCC_STANDBY;
                            s_d.evc = s_q.evc_init;
                            s_d.cnt_en = 1'b1;
                            s_d.ev_irq_en = 1'b1;
                            s_d.armed = 1'b1;
                            tmr_load = 1'b1;
                        end
                    end
                    `GCC_CMD_PAR_POLL: begin
                        if (s_q.ctl == gcc_pkg::GCC_ACTIVE) begin
                            s_d.eoi_out = 1'b1;
                            s_d.ctl = gcc_pkg::GCC_ACT_WAIT;
                            s_d.hold = '0;
                        end
                    end
                    `GCC_CMD_GO_STANDBY: begin
                        if (s_q.ctl == gcc_pkg::GCC_ACTIVE) begin
                            s_d.attn_n = 1'b1;
                            s_d.ctl = gcc_pkg::GCC_STANDBY;
                            s_d.armed = 1'b1;
                            s_d.task_complete_irq = 1'b1;
                            tmr_load = 1'b1;
                        end
                    end
                    `GCC_CMD_LOCAL_MODE, `GCC_CMD_REMOTE_MODE: begin
                        if (syscon) begin
                            s_d.ren_out = (host_data_i == `GCC_CMD_REMOTE_MODE);
                            s_d.task_complete_irq = 1'b1;
                        end else begin
                            new_err[`GCC_ERR_USER] = 1'b1;
                        end
                    end
                    `GCC_CMD_ABORT: begin
                        if (syscon) begin
                            s_d.ifc_out = 1'b1;
                            s_d.ifc_cnt = '0;
                        end else begin
                            new_err[`GCC_ERR_USER] = 1'b1;
                        end
                    end
                    `GCC_CMD_TAKE_CTRL: begin
                        if (s_q.ctl == gcc_pkg::GCC_IDLE) begin
                            s_d.ctl = gcc_pkg::GCC_HANDOVER;
                            tmr_load = 1'b1;
                        end
                    end
                    `GCC_CMD_TAKE_SYNC: begin
                        if (s_q.ctl == gcc_pkg::GCC_STANDBY) begin
                            s_d.ctl = gcc_pkg::GCC_SYNC_WAIT;
                            s_d.cnt_en = 1'b0;
                            s_d.ev_irq_en = 1'b0;
                            s_d.hold = '0;
                            tmr_load = 1'b1;
                        end
                    end
                    default: s_d.task_complete_irq = 1'b0;
                endcase
            end
        end
        // interface clear received while not system controller
        if (s_q.sync2.ifcl && !s_q.sync3.ifcl && !syscon) begin
            s_d.ctl = gcc_pkg::GCC_IDLE;
            s_d.attn_n = 1'b1;
            s_d.cic_n = 1'b1;
            s_d.eoi_out = 1'b0;
            s_d.cnt_en = 1'b0;
            s_d.armed = 1'b0;
            s_d.isr[`GCC_ISR_IFCR] = 1'b1;
        end
        // fault flags set regardless of enable; enable gates the status bit
        s_d.err = s_d.err | new_err;
        if ((new_err & s_q.emask) != 8'h00) begin
            s_d.isr[`GCC_ISR_ERR] = 1'b1;
        end
        // reset clears all state except idle and the two active-low outputs, which go high; a reset by command keeps only the pin samples
        if (!resetn_i || soft_rst) begin
            s_d = '0;
            s_d.ctl = gcc_pkg::GCC_IDLE;
            s_d.dest = gcc_pkg::GCC_TO_MASK;
            s_d.attn_n = 1'b1;
            s_d.cic_n = 1'b1;
            if (resetn_i) begin
                s_d.sync1 = bus_i;
                s_d.sync2 = s_q.sync1;
                s_d.sync3 = s_q.sync2;
            end
        end
        s_d.spi = |s_d.isr;
    end

    // single register stage for all state
    always_ff @(posedge clock_i) begin
        s_q <= s_d;
    end

    // outputs straight from state flip-flops
    always_comb begin
        host_data_o = s_q.obuf;
        irq_status_o = s_q.isr;
        irq_status_o[`GCC_ISR_OBF] = s_q.obf;
        out_full_o = s_q.obf;
        task_complete_irq_o = s_q.task_complete_irq;
        special_irq_o = s_q.spi;
        attention_out_n_o = s_q.attn_n;
        in_charge_out_n_o = s_q.cic_n;
        ren_out_o = s_q.ren_out;
        ifc_out_o = s_q.ifc_out;
        eoi_out_o = s_q.eoi_out;
    end
endmodule

// *** test/gcc_core_props.sv ***
// assertions on the command core ports
// assumes a bind onto gcc_core from the bench top file
`timescale 1ns/1ns
module gcc_core_props (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic port_select_line_i,
    input wire logic [7:0] host_data_i,
    input wire gcc_pkg::gcc_bus_s bus_i,
    input wire logic [7:0] host_data_o,
    input wire logic [7:0] irq_status_o,
    input wire logic out_full_o,
    input wire logic task_complete_irq_o,
    input wire logic special_irq_o,
    input wire logic attention_out_n_o,
    input wire logic in_charge_out_n_o,
    input wire logic ren_out_o,
    input wire logic ifc_out_o,
    input wire logic eoi_out_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // command byte taken this edge
    logic cmd_w;
    assign cmd_w = host_wr_i && port_select_line_i;
    sequence s_cmd(c);
        cmd_w && host_data_i == c;
    endsequence
    sequence s_active;
        !attention_out_n_o && !in_charge_out_n_o;
    endsequence
    property p_rst;
        disable iff (1'b0) !resetn_i |=> attention_out_n_o && in_charge_out_n_o && !ren_out_o;
    endproperty
    property p_rd;
        s_cmd(8'he6) |=> out_full_o && task_complete_irq_o;
    endproperty
    property p_obf;
        host_rd_i && !port_select_line_i && !host_wr_i |=> !out_full_o;
    endproperty
    property p_ren;
        $rose(ren_out_o) |-> $past(cmd_w) && $past(host_data_i) == 8'hf8;
    endproperty
    property p_eoi;
        $rose(eoi_out_o) |-> $past(cmd_w) && $past(host_data_i) == 8'hf5;
    endproperty
    property p_eoi_atn;
        eoi_out_o |-> !attention_out_n_o;
    endproperty
    property p_stby;
        s_cmd(8'hf6) ##0 s_active |=> attention_out_n_o && task_complete_irq_o;
    endproperty
    property p_cic;
        $rose(in_charge_out_n_o) |-> attention_out_n_o;
    endproperty
    a_rst: assert property (p_rst) else $error("reset levels wrong");
    a_rd: assert property (p_rd) else $error("status read not answered");
    a_obf: assert property (p_obf) else $error("buffer full not cleared");
    a_ren: assert property (p_ren) else $error("ren rose without command");
    a_eoi: assert property (p_eoi) else $error("eoi rose without poll");
    a_eoi_atn: assert property (p_eoi_atn) else $error("eoi without attention");
    a_stby: assert property (p_stby) else $error("standby not entered");
    a_cic: assert property (p_cic) else $error("in charge left with atn on");
endmodule

// *** test/gcc_bus_model.sv ***
// cable side model: instruments and switch seen at the core pins
// assumes knobs come from the bench shortly after the clock edge
`timescale 1ns/1ns
module gcc_bus_model (
    input wire logic clock_i,
    input wire logic ren_i,
    input wire logic eoi_i,
    input wire logic ifc_i,
    input wire logic [3:0] knob_i,
    input wire logic [1:0] pulse_i,
    output gcc_pkg::gcc_bus_s bus_o
);
    initial bus_o = '0;
    // lines settle a cycle late; knob dav, syc, attention_in, srq; pulse count, ifcl
    always @(posedge clock_i) begin
        bus_o <= '{ren: ren_i, dav: knob_i[0], eoi: eoi_i, syscon_switch: knob_i[1], ifc: ifc_i,
            attention_in: knob_i[2], srq: knob_i[3], count: pulse_i[0], ifcl: pulse_i[1]};
    end
endmodule

// *** test/gcc_core_tb.sv ***
// self-checking bench of the command core through its host port
// assumes gcc_bus_model stands for the cable side
`timescale 1ns/1ns
module gcc_core_tb;
    logic clock_i, resetn_i, wr, rd, sel, full, task_complete_irq, spi, atn_n, cic_n, ren, ifc, eoi;
    logic [7:0] din, hdo, isr;
    logic [3:0] knob;
    logic [1:0] pls;
    gcc_pkg::gcc_bus_s bus;
    int err_count, n_compared, cyc, k;
    gcc_core i_gcc_core (.clock_i(clock_i), .resetn_i(resetn_i), .host_wr_i(wr),
        .host_rd_i(rd), .port_select_line_i(sel), .host_data_i(din), .bus_i(bus),
        .host_data_o(hdo), .irq_status_o(isr), .out_full_o(full), .task_complete_irq_o(task_complete_irq),
        .special_irq_o(spi), .attention_out_n_o(atn_n), .in_charge_out_n_o(cic_n),
        .ren_out_o(ren), .ifc_out_o(ifc), .eoi_out_o(eoi));
    gcc_bus_model i_gcc_bus_model (.clock_i(clock_i), .ren_i(ren), .eoi_i(eoi), .ifc_i(ifc),
        .knob_i(knob), .pulse_i(pls), .bus_o(bus));
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // hang guard
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    task automatic tk();
        @(posedge clock_i);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_b(input logic s, input logic [7:0] d);
        sel = s;
        din = d;
        wr = 1'b1;
        tk();
        wr = 1'b0;
        tk();
    endtask
    task automatic rd_c(input logic [7:0] c, input logic [7:0] exp);
        wr_b(1'b1, c);
        chk(hdo, exp);
        sel = 1'b0;
        rd = 1'b1;
        tk();
        rd = 1'b0;
        tk();
        chk({7'h0, full}, 8'h00);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {resetn_i, wr, rd, sel, din} = '0;
        pls = 2'h0;
        knob = 4'h2;
        repeat (20) tk();
        resetn_i = 1'b1;
        chk({6'h0, atn_n, cic_n}, 8'h03);
        repeat (4) tk();
        rd_c(8'he6, 8'h08);
        wr_b(1'b0, 8'hff);
        rd_c(8'hea, 8'h27);
        wr_b(1'b1, 8'he2);
        wr_b(1'b0, 8'h05);
        rd_c(8'he3, 8'h05);
        knob = 4'hb;
        repeat (4) tk();
        rd_c(8'he7, 8'h49);
        knob = 4'h2;
        wr_b(1'b1, 8'hf8);
        chk({6'h0, ren, task_complete_irq}, 8'h03);
        wr_b(1'b1, 8'hf7);
        chk({6'h0, ren, task_complete_irq}, 8'h01);
        $display("test registers done");
        knob = 4'h0;
        repeat (4) tk();
        wr_b(1'b1, 8'hf8);
        chk({6'h0, ren, isr[6]}, 8'h01);
        rd_c(8'he4, 8'h20);
        wr_b(1'b1, 8'hf3);
        chk({7'h0, isr[6]}, 8'h00);
        rd_c(8'he4, 8'h00);
        $display("test faults done");
        knob = 4'h2;
        repeat (4) tk();
        wr_b(1'b1, 8'hfa);
        for (k = 0; k < 50 && atn_n !== 1'b0; k++) tk();
        tk();
        chk({5'h0, atn_n, cic_n, task_complete_irq}, 8'h01);
        knob = 4'h2;
        rd_c(8'he6, 8'h48);
        wr_b(1'b1, 8'hf5);
        for (k = 0; k < 10 && eoi !== 1'b1; k++) tk();
        for (k = 0; k < 200 && eoi === 1'b1; k++) tk();
        tk();
        chk({7'h0, k >= 48 && k <= 50}, 8'h01);
        chk({7'h0, task_complete_irq}, 8'h01);
        wr_b(1'b1, 8'hf6);
        chk({6'h0, atn_n, task_complete_irq}, 8'h03);
        rd_c(8'he6, 8'h88);
        wr_b(1'b1, 8'hf1);
        chk({7'h0, task_complete_irq}, 8'h00);
        wr_b(1'b1, 8'hfd);
        for (k = 0; k < 60 && atn_n !== 1'b0; k++) tk();
        chk({7'h0, k >= 36 && k <= 38}, 8'h01);
        chk({6'h0, atn_n, task_complete_irq}, 8'h01);
        wr_b(1'b1, 8'hf1);
        chk({5'h0, atn_n, cic_n, task_complete_irq}, 8'h07);
        wr_b(1'b1, 8'hfa);
        for (k = 0; k < 50 && atn_n !== 1'b0; k++) tk();
        chk({6'h0, atn_n, cic_n}, 8'h00);
        wr_b(1'b1, 8'he2);
        wr_b(1'b0, 8'h02);
        wr_b(1'b1, 8'hf4);
        chk({6'h0, atn_n, task_complete_irq}, 8'h02);
        repeat (2) begin
            pls = 2'h1;
            repeat (4) tk();
            pls = 2'h0;
            repeat (4) tk();
        end
        chk({7'h0, isr[4]}, 8'h01);
        rd_c(8'he3, 8'h00);
        knob = 4'h0;
        repeat (4) tk();
        pls = 2'h2;
        repeat (6) tk();
        pls = 2'h0;
        chk({4'h0, spi, isr[2], atn_n, cic_n}, 8'h0f);
        knob = 4'h2;
        repeat (4) tk();
        wr_b(1'b1, 8'hf9);
        chk({7'h0, ifc}, 8'h01);
        rd_c(8'he6, 8'h0c);
        wr_b(1'b1, 8'hf2);
        repeat (4) tk();
        chk({6'h0, atn_n, cic_n}, 8'h03);
        rd_c(8'he6, 8'h08);
        $display("test control done");
        final_report();
    end
endmodule
bind gcc_core gcc_core_props i_gcc_core_props (.*);
